// ==== common/acc_params.svh ====
// Register map, reset values and fixed figures of the analog command conditioning block
// Contract
// (R1) Two independent channels, each a signed millivolt sample of about plus or minus 10 V.
// (R2) Each channel is low-pass filtered with its own time constant.
// (R3) Filtering does no drift or dead-zone correction; later stages do.
// (R4) Raw sampled voltage of channel A is readable as a display value.
// (R5) After filtering, the channel's stored zero drift is subtracted.
// (R6) The channel's configured bias is subtracted next.
// (R7) Values within the dead-zone width give zero, others pass unchanged.
// (R8) Percentage is dead-zone output over 10000 mV times magnification percentage.
// (R9) Speed mode: speed command is rated speed times the command percentage.
// (R10) Torque mode: the command percentage is the torque command unchanged.
// (R11) Writing 1, 2 or 4 to auto correction captures drift of A, B or both.
// (R12) Falling edge of the drift correction input captures drift of both channels.
// (R13) Filter time constants range 0 to 32767 ms and reset to 2.
// (R14) Stages run in fixed order, one result for every new sample.
// (R15) Magnitude exactly equal to dead-zone width counts as inside, giving zero.
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// Global registers
`define ACC_ADR_CTRL      8'h00
`define ACC_ADR_AUTO      8'h04
`define ACC_ADR_RATED     8'h08
// Channel blocks and offsets inside them
`define ACC_ADR_CHA       8'h10
`define ACC_ADR_CHB       8'h30
`define ACC_OFS_TC        8'h00
`define ACC_OFS_DRIFT     8'h04
`define ACC_OFS_BIAS      8'h08
`define ACC_OFS_DEAD      8'h0c
`define ACC_OFS_MAG       8'h10
`define ACC_OFS_RAW       8'h14
`define ACC_OFS_PCT       8'h18
// Field positions
`define ACC_CTRL_TORQUE   0
// Auto correction codes
`define ACC_AUTO_A        3'h1
`define ACC_AUTO_B        3'h2
`define ACC_AUTO_AB       3'h4
// Reset values
`define ACC_RST_TC        15'h0002
`define ACC_RST_MAG       14'h03e8
`define ACC_RST_RATED     16'h0bb8
// Ranges and scale
`define ACC_BIAS_MAX      10000
`define ACC_DEAD_MAX      5000
`define ACC_MAG_MAX       10000
`define ACC_FULL_SCALE_MV 10000
`define ACC_PERMILLE      1000
`define ACC_PCT_SAT       32767
// Timing: sample period in ns, one millisecond in ns, filter fraction bits
`define ACC_SAMPLE_NS     100000
`define ACC_MS_NS         1000000
`define ACC_FILT_FRAC     16
`define ACC_SHIFT_MAX     20

`endif

// ==== common/acc_pkg.sv ====
// Types shared by the analog command conditioning design
package acc_pkg;
   typedef enum logic [2:0] {
      ACC_ST_IDLE,
      ACC_ST_FILT,
      ACC_ST_CORR,
      ACC_ST_SCALE,
      ACC_ST_OUT
   } acc_state_e;
   typedef logic signed [15:0] acc_mv_t;
endpackage

// ==== hw/acc_fifo.sv ====
// Sample FIFO with registered read data and registered ready
`timescale 1ns/1ps
module acc_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 32
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
         $error("acc_fifo: depth must be a power of two of at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr;
   logic [AW-1:0]    rptr;
   logic [AW:0]      cnt;
   logic [AW-1:0]    next_wptr;
   logic [AW-1:0]    next_rptr;
   logic [AW:0]      next_cnt;
   logic             next_in_ready;
   logic             next_out_valid;
   logic             push;
   logic             load;

   // Output register refills whenever it is empty or being taken
   always_comb begin
      push           = in_valid_i & in_ready_o;
      load           = (~out_valid_o | out_ready_i) & (cnt != '0);
      next_wptr      = push ? wptr + AW'(1) : wptr;
      next_rptr      = load ? rptr + AW'(1) : rptr;
      next_cnt       = cnt + (AW+1)'(push) - (AW+1)'(load);
      next_in_ready  = next_cnt != (AW+1)'(DEPTH);  // Registered from the next count, so full shows in the very cycle it is reached
      next_out_valid = load | (out_valid_o & ~out_ready_i);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wptr        <= '0;
         rptr        <= '0;
         cnt         <= '0;
         in_ready_o  <= 1'b0;
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
      end else begin
         wptr        <= next_wptr;
         rptr        <= next_rptr;
         cnt         <= next_cnt;
         in_ready_o  <= next_in_ready;
         out_valid_o <= next_out_valid;
         if (load) begin
            out_data_o <= mem[rptr];
         end
      end
   end

   // Storage has no reset
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wptr] <= in_data_i;
      end
   end
endmodule

// ==== hw/acc_top.sv ====
// Analog command conditioning: filter, drift, bias, dead zone, scaling, Wishbone registers
`timescale 1ns/1ps
`include "acc_params.svh"
module acc_top #(
   parameter int SAMPLE_NS  = `ACC_SAMPLE_NS,
   parameter int FIFO_DEPTH = 32
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        smp_valid_i,
   input  wire logic        smp_chan_i,
   input  wire logic [15:0] smp_data_i,
   output logic             smp_ready_o,
   input  wire logic        drift_correct_input_function_i,
   output logic             cmd_valid_o,
   input  wire logic        cmd_ready_i,
   output logic             cmd_chan_o,
   output logic             cmd_torque_o,
   output logic      [31:0] cmd_value_o
);
   generate
      if (SAMPLE_NS < 1 || FIFO_DEPTH < 2) begin : g_bad
         $error("acc_top: sample period and FIFO depth must be positive");
      end
   endgenerate

   // Register file, per channel where the parameter is per channel
   logic                ctl_torque;
   logic [1:0]          pend;
   logic [15:0]         rated;
   logic [14:0]         tc    [2];
   acc_pkg::acc_mv_t    drift [2];
   acc_pkg::acc_mv_t    bias  [2];
   logic [12:0]         dead  [2];
   logic [13:0]         mag   [2];
   acc_pkg::acc_mv_t    raw   [2];
   acc_pkg::acc_mv_t    pct   [2];
   logic signed [32:0]  filt  [2];
   logic                fn_prev;
   // Pipeline
   acc_pkg::acc_state_e state;
   logic                cur_ch;
   acc_pkg::acc_mv_t    x;
   acc_pkg::acc_mv_t    yv;
   logic signed [17:0]  b2;
   // Next values
   logic                next_ctl_torque;
   logic [1:0]          next_pend;
   logic [15:0]         next_rated;
   logic [14:0]         next_tc    [2];
   acc_pkg::acc_mv_t    next_drift [2];
   acc_pkg::acc_mv_t    next_bias  [2];
   logic [12:0]         next_dead  [2];
   logic [13:0]         next_mag   [2];
   acc_pkg::acc_mv_t    next_raw   [2];
   acc_pkg::acc_mv_t    next_pct   [2];
   logic signed [32:0]  next_filt  [2];
   acc_pkg::acc_state_e next_state;
   logic                next_cur_ch;
   acc_pkg::acc_mv_t    next_x;
   acc_pkg::acc_mv_t    next_yv;
   logic signed [17:0]  next_b2;
   logic [31:0]         next_wb_dat;
   logic                next_wb_ack;
   logic                next_cmd_valid;
   logic                next_cmd_chan;
   logic                next_cmd_torque;
   logic [31:0]         next_cmd_value;
   // Datapath terms
   logic                fifo_valid;
   logic [16:0]         fifo_data;
   logic                take;
   logic                req;
   logic                wr;
   logic [1:0]          pend_set;
   logic [1:0]          pend_clr;
   logic [4:0]          sh;
   logic signed [33:0]  fdiff;
   logic signed [17:0]  b1;
   logic [17:0]         b1_abs;
   logic signed [32:0]  prod;
   logic signed [32:0]  quo;
   logic signed [32:0]  spd;

   // Samples wait here while a slow consumer holds the pipeline
   acc_fifo #(
      .WIDTH(17),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .in_valid_i (smp_valid_i),
      .in_ready_o (smp_ready_o),
      .in_data_i  ({smp_chan_i, smp_data_i}),
      .out_valid_o(fifo_valid),
      .out_ready_i(take),
      .out_data_o (fifo_data)
   );

   // Shift that approximates the time constant in samples; zero means no filtering
   function automatic logic [4:0] tc_shift(input logic [14:0] tcv);
      logic [39:0] n;
      logic [4:0]  s;
      n = 40'(tcv) * 40'(`ACC_MS_NS) / 40'(SAMPLE_NS);
      s = 5'h00;
      for (int i = 0; i < `ACC_SHIFT_MAX; i++) begin
         if ((40'h1 << s) < n + 40'h1) begin
            s = s + 5'h01;
         end
      end
      return s;
   endfunction

   // Byte-lane merge of write data into a current value
   function automatic logic [31:0] merge(input logic [31:0] cur);
      logic [31:0] m;
      m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      return (cur & ~m) | (wb_dat_i & m);
   endfunction

   // Clamp a written signed value to plus or minus the limit
   function automatic logic signed [15:0] clamp_s(input logic [31:0] v, input int lim);
      logic signed [31:0] sv;
      sv = $signed(v);
      if (sv > lim) return 16'(lim);
      if (sv < -lim) return 16'(-lim);
      return sv[15:0];
   endfunction

   // Stage arithmetic from the current pipeline registers
   always_comb begin
      sh     = tc_shift(tc[cur_ch]);
      fdiff  = {x[15], x[15], x, 16'h0000} - {filt[cur_ch][32], filt[cur_ch]};
      b1     = 18'(yv) - 18'(drift[cur_ch]) - 18'(bias[cur_ch]);    // see R5 see R6
      b1_abs = b1[17] ? 18'(-b1) : 18'(b1);
      prod   = 33'(b2) * $signed({19'h00000, mag[cur_ch]});
      quo    = prod / 33'sd10000;                                   // see R8
      spd    = $signed({17'h00000, rated}) * 33'(pct[cur_ch]) / 33'sd1000;
   end

   // All next values: bus, parameters, drift capture and pipeline
   always_comb begin
      req             = wb_cyc_i & wb_stb_i;
      wr              = req & wb_ack_o & wb_we_i;
      take            = (state == acc_pkg::ACC_ST_IDLE);
      next_wb_ack     = req & ~wb_ack_o;
      next_wb_dat     = wb_dat_o;
      next_ctl_torque = ctl_torque;
      next_rated      = rated;
      pend_set        = 2'h0;
      pend_clr        = 2'h0;
      next_tc         = tc;
      next_drift      = drift;
      next_bias       = bias;
      next_dead       = dead;
      next_mag        = mag;
      next_raw        = raw;
      next_pct        = pct;
      next_filt       = filt;
      next_state      = state;
      next_cur_ch     = cur_ch;
      next_x          = x;
      next_yv         = yv;
      next_b2         = b2;
      next_cmd_valid  = cmd_valid_o;
      next_cmd_chan   = cmd_chan_o;
      next_cmd_torque = cmd_torque_o;
      next_cmd_value  = cmd_value_o;
      // Read data latched at request start; unmapped reads answer zero
      if (req & ~wb_ack_o) begin
         next_wb_dat = 32'h00000000;
         if (wb_adr_i == `ACC_ADR_CTRL) begin
            next_wb_dat[`ACC_CTRL_TORQUE] = ctl_torque;
         end else if (wb_adr_i == `ACC_ADR_AUTO) begin
            next_wb_dat = {30'h00000000, pend};
         end else if (wb_adr_i == `ACC_ADR_RATED) begin
            next_wb_dat = {16'h0000, rated};
         end
         for (int c = 0; c < 2; c++) begin
            if (wb_adr_i == (c == 0 ? `ACC_ADR_CHA : `ACC_ADR_CHB) + `ACC_OFS_TC) begin
               next_wb_dat = {17'h00000, tc[c]};
            end else if (wb_adr_i == (c == 0 ? `ACC_ADR_CHA : `ACC_ADR_CHB) + `ACC_OFS_DRIFT) begin
               next_wb_dat = 32'(drift[c]);
            end else if (wb_adr_i == (c == 0 ? `ACC_ADR_CHA : `ACC_ADR_CHB) + `ACC_OFS_BIAS) begin
               next_wb_dat = 32'(bias[c]);
            end else if (wb_adr_i == (c == 0 ? `ACC_ADR_CHA : `ACC_ADR_CHB) + `ACC_OFS_DEAD) begin
               next_wb_dat = {19'h00000, dead[c]};
            end else if (wb_adr_i == (c == 0 ? `ACC_ADR_CHA : `ACC_ADR_CHB) + `ACC_OFS_MAG) begin
               next_wb_dat = {18'h00000, mag[c]};
            end else if (wb_adr_i == (c == 0 ? `ACC_ADR_CHA : `ACC_ADR_CHB) + `ACC_OFS_RAW) begin
               next_wb_dat = 32'(raw[c]);                           // see R4
            end else if (wb_adr_i == (c == 0 ? `ACC_ADR_CHA : `ACC_ADR_CHB) + `ACC_OFS_PCT) begin
               next_wb_dat = 32'(pct[c]);
            end
         end
      end
      // Writes land on the edge that the master sees ack; drift, bias, dead zone and magnification clamp, others truncate
      if (wr) begin
         if (wb_adr_i == `ACC_ADR_CTRL) begin
            next_ctl_torque = 1'(merge({31'h0, ctl_torque}) >> `ACC_CTRL_TORQUE);
         end else if (wb_adr_i == `ACC_ADR_AUTO) begin
            if (3'(merge(32'h0)) == `ACC_AUTO_A) pend_set = 2'h1;  // see R11
            else if (3'(merge(32'h0)) == `ACC_AUTO_B) pend_set = 2'h2;
            else if (3'(merge(32'h0)) == `ACC_AUTO_AB) pend_set = 2'h3;
         end else if (wb_adr_i == `ACC_ADR_RATED) begin
            next_rated = 16'(merge({16'h0000, rated}));
         end
         for (int c = 0; c < 2; c++) begin
            if (wb_adr_i == (c == 0 ? `ACC_ADR_CHA : `ACC_ADR_CHB) + `ACC_OFS_TC) begin
               next_tc[c] = 15'(merge({17'h00000, tc[c]}));         // see R13
            end else if (wb_adr_i == (c == 0 ? `ACC_ADR_CHA : `ACC_ADR_CHB) + `ACC_OFS_DRIFT) begin
               next_drift[c] = clamp_s(merge(32'(drift[c])), 32767);
            end else if (wb_adr_i == (c == 0 ? `ACC_ADR_CHA : `ACC_ADR_CHB) + `ACC_OFS_BIAS) begin
               next_bias[c] = clamp_s(merge(32'(bias[c])), `ACC_BIAS_MAX);
            end else if (wb_adr_i == (c == 0 ? `ACC_ADR_CHA : `ACC_ADR_CHB) + `ACC_OFS_DEAD) begin
               next_dead[c] = 13'(clamp_s(merge({19'h00000, dead[c]}), `ACC_DEAD_MAX) & 16'h1fff);
            end else if (wb_adr_i == (c == 0 ? `ACC_ADR_CHA : `ACC_ADR_CHB) + `ACC_OFS_MAG) begin
               next_mag[c] = 14'(clamp_s(merge({18'h00000, mag[c]}), `ACC_MAG_MAX) & 16'h3fff);
            end
         end
      end
      // Valid-to-invalid transition of the input requests both captures
      if (fn_prev & ~drift_correct_input_function_i) begin
         pend_set = 2'h3;                                           // see R12
      end
      // One sample through the fixed stage order
      case (state)
         acc_pkg::ACC_ST_IDLE: begin
            if (fifo_valid) begin
               next_cur_ch = fifo_data[16];                         // see R1
               next_x      = fifo_data[15:0];
               next_raw[fifo_data[16]] = fifo_data[15:0];           // see R4
               if (pend[fifo_data[16]]) begin
                  next_drift[fifo_data[16]] = fifo_data[15:0];      // see R11
                  pend_clr[fifo_data[16]]   = 1'b1;
               end
               next_state = acc_pkg::ACC_ST_FILT;                   // see R14
            end
         end
         acc_pkg::ACC_ST_FILT: begin
            // First-order low pass on the raw sample only
            next_filt[cur_ch] = filt[cur_ch] + 33'(fdiff >>> sh);   // see R2 see R3
            next_yv           = 16'((filt[cur_ch] + 33'(fdiff >>> sh)) >>> `ACC_FILT_FRAC);
            next_state        = acc_pkg::ACC_ST_CORR;
         end
         acc_pkg::ACC_ST_CORR: begin
            next_b2    = (b1_abs <= 18'(dead[cur_ch])) ? 18'sh00000 : b1; // see R7 see R15
            next_state = acc_pkg::ACC_ST_SCALE;
         end
         acc_pkg::ACC_ST_SCALE: begin
            // Percentage in 0.1 % units, held to the display range
            if (quo > 33'sd32767) next_pct[cur_ch] = 16'sd32767;    // see R8
            else if (quo < -33'sd32767) next_pct[cur_ch] = -16'sd32767;
            else next_pct[cur_ch] = quo[15:0];
            next_state = acc_pkg::ACC_ST_OUT;
         end
         acc_pkg::ACC_ST_OUT: begin
            if (~cmd_valid_o) begin
               next_cmd_valid  = 1'b1;
               next_cmd_chan   = cur_ch;
               next_cmd_torque = ctl_torque;
               next_cmd_value  = ctl_torque ? 32'(pct[cur_ch])     // see R10
                                            : spd[31:0];            // see R9
            end else if (cmd_ready_i) begin
               next_cmd_valid = 1'b0;
               next_state     = acc_pkg::ACC_ST_IDLE;
            end
         end
         default: next_state = acc_pkg::ACC_ST_IDLE;
      endcase
      // A new request wins over a capture in the same cycle
      next_pend = (pend & ~pend_clr) | pend_set;
   end

   // Registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o     <= 1'b0;
         wb_dat_o     <= 32'h00000000;
         ctl_torque   <= 1'b0;
         pend         <= 2'h0;
         rated        <= `ACC_RST_RATED;
         tc           <= '{`ACC_RST_TC, `ACC_RST_TC};               // see R13
         drift        <= '{16'sh0000, 16'sh0000};
         bias         <= '{16'sh0000, 16'sh0000};
         dead         <= '{13'h0000, 13'h0000};
         mag          <= '{`ACC_RST_MAG, `ACC_RST_MAG};
         raw          <= '{16'sh0000, 16'sh0000};
         pct          <= '{16'sh0000, 16'sh0000};
         filt         <= '{33'sh0, 33'sh0};
         fn_prev      <= 1'b0;
         state        <= acc_pkg::ACC_ST_IDLE;
         cur_ch       <= 1'b0;
         x            <= 16'sh0000;
         yv           <= 16'sh0000;
         b2           <= 18'sh00000;
         cmd_valid_o  <= 1'b0;
         cmd_chan_o   <= 1'b0;
         cmd_torque_o <= 1'b0;
         cmd_value_o  <= 32'h00000000;
      end else begin
         wb_ack_o     <= next_wb_ack;
         wb_dat_o     <= next_wb_dat;
         ctl_torque   <= next_ctl_torque;
         pend         <= next_pend;
         rated        <= next_rated;
         tc           <= next_tc;
         drift        <= next_drift;
         bias         <= next_bias;
         dead         <= next_dead;
         mag          <= next_mag;
         raw          <= next_raw;
         pct          <= next_pct;
         filt         <= next_filt;
         fn_prev      <= drift_correct_input_function_i;
         state        <= next_state;
         cur_ch       <= next_cur_ch;
         x            <= next_x;
         yv           <= next_yv;
         b2           <= next_b2;
         cmd_valid_o  <= next_cmd_valid;
         cmd_chan_o   <= next_cmd_chan;
         cmd_torque_o <= next_cmd_torque;
         cmd_value_o  <= next_cmd_value;
      end
   end

   // Checks on the stage chain and the register side
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_stage_order: assert property ((state == acc_pkg::ACC_ST_IDLE) && fifo_valid |=> // see R14
      (state == acc_pkg::ACC_ST_FILT) ##1 (state == acc_pkg::ACC_ST_CORR) ##1
      (state == acc_pkg::ACC_ST_SCALE) ##1 (state == acc_pkg::ACC_ST_OUT)) else $error("stage order broken");
   a_filter_bypass: assert property ((state == acc_pkg::ACC_ST_FILT) && (sh == 5'h00) |=> // see R2
      (yv == $past(x))) else $error("zero time constant must pass sample");
   a_dead_inside: assert property ((state == acc_pkg::ACC_ST_CORR) && (b1_abs <= 18'(dead[cur_ch])) |=> // see R15
      (b2 == 18'sh00000)) else $error("dead zone value not zero");
   a_dead_outside: assert property ((state == acc_pkg::ACC_ST_CORR) && (b1_abs > 18'(dead[cur_ch])) |=> // see R7
      (b2 == $past(b1))) else $error("value outside dead zone altered");
   a_auto_both: assert property (wr && (wb_adr_i == `ACC_ADR_AUTO) && (wb_sel_i[0]) && // see R11
      (wb_dat_i[2:0] == `ACC_AUTO_AB) |=> (pend == 2'h3)) else $error("auto code 4 not pending both");
   a_input_edge: assert property ($fell(drift_correct_input_function_i) |=> // see R12
      (pend == 2'h3)) else $error("input edge did not request capture");
   a_torque_direct: assert property ($rose(cmd_valid_o) && cmd_torque_o |-> // see R10
      (cmd_value_o == 32'(pct[cmd_chan_o]))) else $error("torque command not the percentage");
   a_raw_seen: assert property ((state == acc_pkg::ACC_ST_IDLE) && fifo_valid |=> // see R4
      (raw[cur_ch] == x)) else $error("raw display not updated");
   a_tc_reset: assert property ($past(rst_i) |-> (tc[0] == `ACC_RST_TC) && (tc[1] == `ACC_RST_TC)) // see R13
      else $error("time constant reset value wrong");
   a_bus_ack: assert property (req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");

   c_speed_out:  cover property ($rose(cmd_valid_o) && !cmd_torque_o);
   c_torque_out: cover property ($rose(cmd_valid_o) && cmd_torque_o);
   c_dead_hit:   cover property ((state == acc_pkg::ACC_ST_CORR) && (b1 != 18'sh0) && (b1_abs <= 18'(dead[cur_ch])));
   c_fifo_full:  cover property ((!smp_ready_o && fifo_valid) ##1 smp_ready_o);
endmodule

// ==== test/acc_adc_model.sv ====
// Converter model offering millivolt samples to the block
`timescale 1ns/1ps
module acc_adc_model (
   input  wire logic        clk_i,
   input  wire logic        ready_i,
   output logic             valid_o,
   output logic             chan_o,
   output logic      [15:0] data_o
);
   // Idle bus at time zero
   initial begin
      valid_o = 1'b0;
      chan_o  = 1'b0;
      data_o  = 16'h0000;
   end
   // One sample, held until taken at a ready edge
   task automatic send(input logic ch, input logic [15:0] mv);
      @(posedge clk_i);
      valid_o <= 1'b1;
      chan_o  <= ch;
      data_o  <= mv;
      do @(posedge clk_i); while (ready_i !== 1'b1);
      valid_o <= 1'b0;
      data_o  <= ~mv; // Stale sample must not look valid
   endtask
endmodule

// ==== test/tb_analog_command_conditioning.sv ====
// Self-checking bench for the analog command conditioning block
`timescale 1ns/1ps
`include "acc_params.svh"
module tb_analog_command_conditioning;
   logic        clk_i, rst_i, cyc, we, sv, sch, rdy, dcin, ack, srdy, cv, cch, ctq;
   logic [7:0]  adr, b;
   logic [15:0] sd;
   logic [31:0] wd, rd, rdat, cval;
   int          n_errors, checks_done, n_res, cc, acc, n0;
   int          rows [8][6] = '{'{0,5000,0,0,1000,1}, '{1,-3000,0,0,1000,1}, '{0,4800,4000,800,1000,1},
      '{0,4801,4000,800,1000,1}, '{0,3199,4000,800,1000,1}, '{1,10000,0,0,10000,0}, '{1,-2345,0,0,500,0},
      '{0,1234,-1000,100,2500,0}};
   acc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .smp_valid_i(sv), .smp_chan_i(sch),
      .smp_data_i(sd), .smp_ready_o(srdy), .drift_correct_input_function_i(dcin), .cmd_valid_o(cv),
      .cmd_ready_i(rdy), .cmd_chan_o(cch), .cmd_torque_o(ctq), .cmd_value_o(cval));
   acc_adc_model adc (.clk_i(clk_i), .ready_i(srdy), .valid_o(sv), .chan_o(sch), .data_o(sd));
   // Expected result; int division truncates toward zero as the block does
   function automatic int ev(int x, int bi, int dz, int mg, int tq);
      int p;
      p = x - bi;
      if (p <= dz && p >= -dz) p = 0;
      p = p * mg / 10000;
      return tq ? p : int'(`ACC_RST_RATED) * p / 1000;
   endfunction
   task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s expected %0d seen %0d", nm, e, s);
      end
   endtask
   task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      we  <= w;
      adr <= a;
      wd  <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = rd;
      cyc <= 1'b0;
   endtask
   task automatic rc(string nm, logic [7:0] a, logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(nm, rdat, e);
   endtask
   // Send one sample, wait for its result; empty name skips the value and mode checks
   task automatic run(string nm, logic ch, logic [15:0] mv, logic [31:0] e, logic tq);
      int k;
      adc.send(ch, mv);
      k = 0;
      do begin
         @(negedge clk_i);
         k++;
      end while (cv !== 1'b1 && k < 100);
      chk("valid", {31'h0, cv}, 32'h1);
      chk("chan", {31'h0, cch}, {31'h0, ch});
      if (nm != "") begin
         chk(nm, cval, e);
         chk("mode", {31'h0, ctq}, {31'h0, tq});
      end
      @(posedge clk_i);
   endtask
   task automatic wrap_up();
      if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // 200 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // Hang guard, far beyond the several hundred cycles needed
   always @(posedge clk_i) begin
      cc++;
      if (cc == 20000) begin
         n_errors++;
         wrap_up();
      end
      if (cv === 1'b1 && rdy === 1'b1) n_res++;
   end
   initial begin
      {rst_i, rdy, cyc, we, dcin, adr, wd} = {2'b11, 43'h0};
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rc("tc", `ACC_ADR_CHA + `ACC_OFS_TC, 32'h2);
      rc("mag", `ACC_ADR_CHB + `ACC_OFS_MAG, 32'h3e8);
      rc("rated", `ACC_ADR_RATED, 32'hbb8);
      rc("unmapped", 8'h7c, 32'h0);
      wb(1'b1, `ACC_ADR_CTRL, 32'h1);
      run("filt", 1'b0, 16'h2710, 32'h1f, 1'b1);
      rc("raw", `ACC_ADR_CHA + `ACC_OFS_RAW, 32'h2710);
      wb(1'b1, `ACC_ADR_CHA + `ACC_OFS_TC, 32'h0);
      wb(1'b1, `ACC_ADR_CHB + `ACC_OFS_TC, 32'h0);
      rc("tc0", `ACC_ADR_CHB + `ACC_OFS_TC, 32'h0);
      for (int i = 0; i < 8; i++) begin
         b = rows[i][0] ? `ACC_ADR_CHB : `ACC_ADR_CHA;
         wb(1'b1, `ACC_ADR_CTRL, 32'(rows[i][5]));
         wb(1'b1, b + `ACC_OFS_BIAS, 32'(rows[i][2]));
         wb(1'b1, b + `ACC_OFS_DEAD, 32'(rows[i][3]));
         wb(1'b1, b + `ACC_OFS_MAG, 32'(rows[i][4]));
         run("cmd", rows[i][0][0], 16'(rows[i][1]), 32'(ev(rows[i][1], rows[i][2], rows[i][3], rows[i][4],
            rows[i][5])), rows[i][5][0]);
      end
      wb(1'b1, `ACC_ADR_AUTO, 32'h1);
      run("", 1'b0, 16'd400, 32'h0, 1'b0);
      rc("drift", `ACC_ADR_CHA + `ACC_OFS_DRIFT, 32'd400);
      run("corr", 1'b0, 16'd400, 32'(ev(0, -1000, 100, 2500, 0)), 1'b0);
      dcin <= 1'b1;
      @(posedge clk_i);
      dcin <= 1'b0;
      run("", 1'b1, 16'd700, 32'h0, 1'b0);
      rc("drift_b", `ACC_ADR_CHB + `ACC_OFS_DRIFT, 32'd700);
      rc("pend", `ACC_ADR_AUTO, 32'h1);
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, `ACC_ADR_AUTO, 32'(1 << i));
         rc("pend", `ACC_ADR_AUTO, 32'(i == 2 ? 3 : 1 << i));
         run("", 1'b0, 16'h0, 32'h0, 1'b0);
         run("", 1'b1, 16'h0, 32'h0, 1'b0);
         rc("idle", `ACC_ADR_AUTO, 32'h0);
      end
      rdy <= 1'b0;
      {acc, n0} = {32'd0, n_res};
      while (srdy === 1'b1 && acc < 64) begin
         adc.send(1'b0, 16'(acc));
         acc++;
         @(negedge clk_i);
      end
      chk("fill", 32'(acc >= 32 && acc < 64), 32'h1);
      @(posedge clk_i);
      rdy <= 1'b1;
      repeat (300) @(posedge clk_i);
      chk("drain", 32'(n_res - n0), 32'(acc));
      // Mid-run reset must restore defaults written over above
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("cv_rst", {31'h0, cv}, 32'h0);
      rc("tc_rst", `ACC_ADR_CHB + `ACC_OFS_TC, 32'h2);
      rc("ctl_rst", `ACC_ADR_CTRL, 32'h0);
      wrap_up();
   end
endmodule
